/* shared/pccr_pkg.sv */
// Purpose: constants for the dual-channel PWM configuration command bank
// Assumes: 250 MHz clock, two channels, byte-wide commands
// Notes:   How it works list below
// How it works
// R1 - Shared clock byte refused while either channel runs
// R2 - Host writes zero to shared byte bits 7:6
// R3 - Mode 0: clock enabled once input reaches on-level
// R4 - Mode 1: clock low from off-level until on-level
// R5 - Phase field selects channel offsets and duty cap
// R6 - Run pin pulsed low after off command
// R7 - Bit 4 set: run pin not pulsed
// R8 - Bit 3 clear: follow on/off exactly
// R9 - Bit 3 set: short cycle forces off, minimum off
// R10 - Bit 2 set: output off while shared clock low
// R11 - Bit 0 clear: retry waits for output decay
// R12 - Mode byte refused while addressed channel runs
// R13 - Mode bit 5 clear: base-emitter difference method
// R14 - Mode bit 5 set: direct voltage method
// R15 - Mode bit 7 selects output voltage range
// R16 - Servo enable ignored when load line nonzero
// R17 - Mode bits 4:3 select bootstrap refresh width
// R18 - Mode bit 1 suppresses discontinuous and overshoot response
// R19 - Mode bit 0 selects conduction mode
// R20 - Shared byte: code F5, default 14, unpaged
// R21 - Paged bytes D0/D4, defaults 1D/C8
// R22 - Accepted write stored, read returns it
package pccr_pkg;
  localparam logic [7:0] CODE_CLOCK_CFG  = 8'h00_F5;
  localparam logic [7:0] CODE_CHAN_CFG   = 8'h00_D0;
  localparam logic [7:0] CODE_PWM_MODE   = 8'h00_D4;
  localparam logic [7:0] RST_CLOCK_CFG   = 8'h00_14;
  localparam logic [7:0] RST_CHAN_CFG    = 8'h00_1D;
  localparam logic [7:0] RST_PWM_MODE    = 8'h00_C8;
  localparam logic [1:0] PAGE_ALL        = 2'h3;
  // Shared clock byte fields
  localparam int CLK_GATE_BIT   = 4;
  localparam int PHASE_LSB      = 0;
  // Channel behaviour byte fields
  localparam int RUN_HOLD_BIT   = 4;
  localparam int SHORT_CYC_BIT  = 3;
  localparam int CLK_DIS_BIT    = 2;
  localparam int NO_DECAY_BIT   = 0;
  // Mode byte fields
  localparam int RANGE_BIT      = 7;
  localparam int SERVO_BIT      = 6;
  localparam int TEMP_DIR_BIT   = 5;
  localparam int BOOTSTRAP_REFRESH_LSB      = 3;
  localparam int NO_DCM_BIT     = 1;
  localparam int DCM_BIT        = 0;
  // Timing
  localparam int CLK_KHZ        = 250000;
  localparam int MS_PER_TICK    = 1;
  localparam int MS_CYCLES      = CLK_KHZ * MS_PER_TICK;
  localparam int RUN_EXTRA_MS   = 136;
  localparam int MIN_OFF_MS     = 120;
  // Cap codes: 0 = 83.3 percent, 1 = 87.5 percent
  localparam logic DUTY_CAP_833 = 1'b0;
  localparam logic DUTY_CAP_875 = 1'b1;
  typedef enum {PCCR_OFF, PCCR_ON, PCCR_OFF_SEQ, PCCR_HOLD_OFF} pccr_state_t;
endpackage

/* verilog/pccr_top.sv */
// Purpose: PWM clocking, channel behaviour and mode command bank
// Assumes: command port is decoded bus transaction, same clock
// Notes:   analog comparator and decay inputs are synchronised here
`timescale 1ns/1ps
`default_nettype none
module pccr_top
  import pccr_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
)(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic [1:0] cmd_page_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ack_o,
  output logic            cmd_nack_o,
  output logic [7:0]      rd_data_o,
  output logic            busy_fault_o,
  input  wire logic       clear_faults_i,
  input  wire logic       input_on_threshold_i,
  input  wire logic       input_off_threshold_i,
  output logic            shared_phase_clock_en_o,
  input  wire logic [1:0] chan_on_cmd_i,
  input  wire logic [1:0] output_decayed_i,
  input  wire logic [1:0] load_line_zero_i,
  input  wire logic [15:0] turn_off_delay_ms_i,
  input  wire logic [15:0] turn_off_ramp_time_ms_i,
  input  wire logic [15:0] restart_wait_time_ms_i,
  output logic [1:0]      chan_enable_o,
  output logic [1:0]      channel_run_input_o,
  output logic [1:0]      channel_run_input_oe_o,
  output logic [8:0]      phase_ch0_deg_o,
  output logic [8:0]      phase_ch1_deg_o,
  output logic            duty_cap_o,
  output logic [1:0]      low_range_o,
  output logic [1:0]      servo_en_o,
  output logic [1:0]      temp_direct_o,
  output logic [7:0]      bootstrap_refresh_width_ns_o [2],
  output logic [1:0]      dcm_allowed_o,
  output logic [1:0]      overshoot_resp_en_o
);
  initial
  begin
    if (MS_CYCLES_P < 2)
    begin
      $error("MS_CYCLES_P must be at least 2");
    end
  end

  logic [7:0]  clock_cfg_q;
  logic [7:0]  chan_cfg_q [2];
  logic [7:0]  mode_q [2];
  logic [1:0]  running;
  logic [2:0]  on_meta_q, on_sync_q;
  logic [1:0]  dec_meta_q, dec_sync_q;
  logic [31:0] div_q;
  logic        ms_tick;
  logic        shared_phase_clock_q;

  // Comparator and decay inputs are asynchronous to this clock
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      on_meta_q  <= 3'h0;
      on_sync_q  <= 3'h0;
      dec_meta_q <= 2'h0;
      dec_sync_q <= 2'h0;
    end
    else
    begin
      on_meta_q  <= {input_off_threshold_i, input_on_threshold_i, 1'b0};
      on_sync_q  <= on_meta_q;
      dec_meta_q <= output_decayed_i;
      dec_sync_q <= dec_meta_q;
    end
  end

  // Millisecond enable for all channel timers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_q <= 32'h0000_0000;
    end
    else if (div_q == 32'(MS_CYCLES_P - 1))
    begin
      div_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_q + 32'h0000_0001;
    end
  end
  assign ms_tick = (div_q == 32'(MS_CYCLES_P - 1));

  // on_sync_q[1] is input at/above on-level, [2] at/below off-level
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shared_phase_clock_q <= 1'b0;
    end
    else
    begin
      if (!clock_cfg_q[CLK_GATE_BIT])
      begin
        shared_phase_clock_q <= shared_phase_clock_q | on_sync_q[1]; // R3
      end
      else if (on_sync_q[2])
      begin
        shared_phase_clock_q <= 1'b0; // R4
      end
      else if (on_sync_q[1])
      begin
        shared_phase_clock_q <= 1'b1; // R4
      end
    end
  end
  assign shared_phase_clock_en_o = shared_phase_clock_q;

  // Command decode; busy refusal checks the channels the byte affects
  logic       is_clk, is_chan, is_mode, known, busy_hit;
  logic [1:0] pg_mask;
  logic [7:0] rd_d;
  logic [0:0] pg_sel;
  always_comb
  begin
    is_clk  = (cmd_code_i == CODE_CLOCK_CFG);
    is_chan = (cmd_code_i == CODE_CHAN_CFG);
    is_mode = (cmd_code_i == CODE_PWM_MODE);
    known   = is_clk | is_chan | is_mode;
    pg_mask = (cmd_page_i == PAGE_ALL) ? 2'h3 : (2'h1 << cmd_page_i[0]);
    pg_sel  = cmd_page_i[0];
    busy_hit = 1'b0;
    if (is_clk)
    begin
      busy_hit = |running; // R1
    end
    else if (is_mode)
    begin
      busy_hit = |(running & pg_mask); // R12
    end
    rd_d = 8'h00_00;
    if (is_clk)
    begin
      rd_d = clock_cfg_q;
    end
    else if (is_chan)
    begin
      rd_d = chan_cfg_q[pg_sel];
    end
    else if (is_mode)
    begin
      rd_d = mode_q[pg_sel];
    end
  end

  logic wr_ok;
  assign wr_ok = cmd_valid_i & cmd_write_i & known & ~busy_hit;

  // Storage; an accepted write lands, a read returns it
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      clock_cfg_q <= RST_CLOCK_CFG; // R20
      for (int i = 0; i < 2; i++)
      begin
        chan_cfg_q[i] <= RST_CHAN_CFG; // R21
        mode_q[i]     <= RST_PWM_MODE; // R21
      end
    end
    else if (wr_ok)
    begin
      if (is_clk)
      begin
        clock_cfg_q <= cmd_data_i; // R22
      end
      for (int i = 0; i < 2; i++)
      begin
        if (pg_mask[i] && is_chan)
        begin
          chan_cfg_q[i] <= cmd_data_i; // R22
        end
        if (pg_mask[i] && is_mode)
        begin
          mode_q[i] <= cmd_data_i; // R22
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_ack_o  <= 1'b0;
      cmd_nack_o <= 1'b0;
      rd_data_o  <= 8'h00_00;
    end
    else
    begin
      cmd_ack_o  <= cmd_valid_i & known & ~(cmd_write_i & busy_hit);
      cmd_nack_o <= cmd_valid_i & (~known | (cmd_write_i & busy_hit));
      if (cmd_valid_i && !cmd_write_i)
      begin
        rd_data_o <= rd_d; // R22
      end
    end
  end

  // Sticky busy fault; a new refusal beats a same-cycle clear
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_fault_o <= 1'b0;
    end
    else if (cmd_valid_i && cmd_write_i && known && busy_hit)
    begin
      busy_fault_o <= 1'b1; // R1 R12
    end
    else if (clear_faults_i)
    begin
      busy_fault_o <= 1'b0;
    end
  end

  // Reserved bits 7:6 are stored as written; the host keeps them zero R2
  always_comb
  begin
    duty_cap_o = clock_cfg_q[PHASE_LSB + 2] ? DUTY_CAP_875 : DUTY_CAP_833;
    case (clock_cfg_q[PHASE_LSB +: 3]) // R5
      3'h7:    begin phase_ch0_deg_o = 9'd135; phase_ch1_deg_o = 9'd315; end
      3'h6:    begin phase_ch0_deg_o = 9'd90;  phase_ch1_deg_o = 9'd270; end
      3'h5:    begin phase_ch0_deg_o = 9'd45;  phase_ch1_deg_o = 9'd225; end
      3'h4:    begin phase_ch0_deg_o = 9'd0;   phase_ch1_deg_o = 9'd180; end
      3'h3:    begin phase_ch0_deg_o = 9'd120; phase_ch1_deg_o = 9'd300; end
      3'h2:    begin phase_ch0_deg_o = 9'd60;  phase_ch1_deg_o = 9'd240; end
      3'h1:    begin phase_ch0_deg_o = 9'd0;   phase_ch1_deg_o = 9'd180; end
      default: begin phase_ch0_deg_o = 9'd0;   phase_ch1_deg_o = 9'd120; end
    endcase
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    pccr_state_t st_q;
    logic [17:0] tmr_q;
    logic [17:0] run_q;
    logic [17:0] pulse_len;
    logic [17:0] seq_len;
    logic        on_prev_q;
    logic        clk_kill;
    logic        retry_ok;
    logic        off_edge;

    // Temperature method and analog range flags leave as levels
    assign low_range_o[c]   = mode_q[c][RANGE_BIT]; // R15
    assign servo_en_o[c]    = mode_q[c][SERVO_BIT] & load_line_zero_i[c]; // R16
    assign temp_direct_o[c] = mode_q[c][TEMP_DIR_BIT]; // R13 R14
    assign dcm_allowed_o[c] = mode_q[c][DCM_BIT] & ~mode_q[c][NO_DCM_BIT]; // R18 R19
    assign overshoot_resp_en_o[c] = ~mode_q[c][NO_DCM_BIT]; // R18
    always_comb
    begin
      case (mode_q[c][BOOTSTRAP_REFRESH_LSB +: 2]) // R17
        2'h3:    bootstrap_refresh_width_ns_o[c] = 8'd250;
        2'h2:    bootstrap_refresh_width_ns_o[c] = 8'd125;
        2'h1:    bootstrap_refresh_width_ns_o[c] = 8'd50;
        default: bootstrap_refresh_width_ns_o[c] = 8'd25;
      endcase
    end

    assign seq_len = 18'(turn_off_delay_ms_i) + 18'(turn_off_ramp_time_ms_i);
    assign pulse_len = (seq_len + 18'(RUN_EXTRA_MS) > 18'(restart_wait_time_ms_i))
                     ? seq_len + 18'(RUN_EXTRA_MS)
                     : 18'(restart_wait_time_ms_i); // R6
    assign clk_kill = chan_cfg_q[c][CLK_DIS_BIT] & ~shared_phase_clock_q; // R10
    assign retry_ok = chan_cfg_q[c][NO_DECAY_BIT] | dec_sync_q[c]; // R11
    assign off_edge = on_prev_q & ~chan_on_cmd_i[c];

    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        st_q  <= PCCR_OFF;
        tmr_q <= 18'h0;
      end
      else
      begin
        if (ms_tick && tmr_q != 18'h0)
        begin
          tmr_q <= tmr_q - 18'h1;
        end
        case (st_q)
          PCCR_OFF:
          begin
            if (chan_on_cmd_i[c] && retry_ok && !clk_kill) // R11
            begin
              st_q <= PCCR_ON;
            end
          end
          PCCR_ON:
          begin
            if (clk_kill)
            begin
              st_q <= PCCR_OFF; // R10
            end
            else if (!chan_on_cmd_i[c])
            begin
              st_q  <= PCCR_OFF_SEQ;
              tmr_q <= seq_len;
            end
          end
          PCCR_OFF_SEQ:
          begin
            if (clk_kill)
            begin
              st_q <= PCCR_OFF;
            end
            else if (chan_on_cmd_i[c] && chan_cfg_q[c][SHORT_CYC_BIT])
            begin
              st_q  <= PCCR_HOLD_OFF; // R9
              tmr_q <= chan_cfg_q[c][RUN_HOLD_BIT] ? 18'(MIN_OFF_MS)
                     : 18'(MIN_OFF_MS) + pulse_len; // R9
            end
            else if (chan_on_cmd_i[c])
            begin
              st_q <= PCCR_ON; // R8
            end
            else if (tmr_q == 18'h0)
            begin
              st_q <= PCCR_OFF;
            end
          end
          PCCR_HOLD_OFF:
          begin
            if (tmr_q == 18'h0)
            begin
              st_q <= PCCR_OFF;
            end
          end
          default:
          begin
            st_q <= PCCR_OFF;
          end
        endcase
      end
    end

    // Run pin pulse timer runs apart from the channel sequence
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        run_q     <= 18'h0;
        on_prev_q <= 1'b0;
      end
      else
      begin
        on_prev_q <= chan_on_cmd_i[c];
        if (off_edge && !chan_cfg_q[c][RUN_HOLD_BIT])
        begin
          run_q <= pulse_len; // R6
        end
        else if (ms_tick && run_q != 18'h0)
        begin
          run_q <= run_q - 18'h1;
        end
      end
    end

    assign running[c] = (st_q != PCCR_OFF) && (st_q != PCCR_HOLD_OFF);
    assign chan_enable_o[c] = (st_q == PCCR_ON) || (st_q == PCCR_OFF_SEQ);
    assign channel_run_input_o[c]    = 1'b0;
    assign channel_run_input_oe_o[c] = (run_q != 18'h0); // R6 R7
  end
endmodule
`default_nettype wire

/* tb/pccr_host_model.sv */
// Purpose: host side of the command port, one byte command per call
// Assumes: one-cycle command pulse, answer registered on the taking edge and read half a cycle after it
// Notes:   released code and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module pccr_host_model
  import pccr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  input  wire logic       nack_i,
  input  wire logic [7:0] rd_i,
  output logic            valid_o,
  output logic            write_o,
  output logic [7:0]      code_o,
  output logic [1:0]      page_o,
  output logic [7:0]      data_o
);
  initial
  begin
    valid_o = 1'b0;
    write_o = 1'b0;
    code_o  = 8'h00;
    page_o  = 2'd0;
    data_o  = 8'h00;
  end
  // Host only writes while it believes the channels are off; tests
  // that want a refusal issue the write anyway
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [1:0] p, input logic [7:0] d,
                      output logic [1:0] an, output logic [7:0] r);
    @(negedge clk_i);
    valid_o = 1'b1;
    write_o = w;
    code_o  = c;
    page_o  = p;
    data_o  = (c == CODE_CLOCK_CFG) ? (d & 8'h3F) : d;
    @(negedge clk_i);
    valid_o = 1'b0;
    data_o  = ~data_o;
    code_o  = ~code_o;
    an      = {ack_i, nack_i};
    r       = rd_i;
  endtask
endmodule
`default_nettype wire

/* tb/pccr_top_assertions.sv */
// Purpose: port-level checks of the configuration command bank
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   only ports are visible, so stored bytes are inferred
`timescale 1ns/1ps
`default_nettype none
module pccr_checker
  import pccr_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
)(
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [1:0] cmd_page_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic       cmd_ack_o,
  input wire logic       cmd_nack_o,
  input wire logic [7:0] rd_data_o,
  input wire logic       busy_fault_o,
  input wire logic       clear_faults_i,
  input wire logic       input_on_threshold_i,
  input wire logic       shared_phase_clock_en_o,
  input wire logic [1:0] chan_on_cmd_i,
  input wire logic [1:0] load_line_zero_i,
  input wire logic [1:0] chan_enable_o,
  input wire logic [8:0] phase_ch0_deg_o,
  input wire logic [8:0] phase_ch1_deg_o,
  input wire logic       duty_cap_o,
  input wire logic [1:0] servo_en_o,
  input wire logic [7:0] bootstrap_refresh_width_ns_o [2],
  input wire logic [1:0] dcm_allowed_o,
  input wire logic [1:0] overshoot_resp_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  function automatic logic [18:0] tbl(input logic [7:0] f);
    case (f[2:0])
      3'h7: tbl = {9'h087, 9'h13B, 1'b1};
      3'h6: tbl = {9'h05A, 9'h10E, 1'b1};
      3'h5: tbl = {9'h02D, 9'h0E1, 1'b1};
      3'h4: tbl = {9'h000, 9'h0B4, 1'b1};
      3'h3: tbl = {9'h078, 9'h12C, 1'b0};
      3'h2: tbl = {9'h03C, 9'h0F0, 1'b0};
      3'h1: tbl = {9'h000, 9'h0B4, 1'b0};
      default: tbl = {9'h000, 9'h078, 1'b0};
    endcase
  endfunction
  sequence s_clk_wr;
    cmd_valid_i && cmd_write_i && cmd_code_i == CODE_CLOCK_CFG;
  endsequence
  sequence s_mode_wr;
    cmd_valid_i && cmd_write_i && cmd_code_i == CODE_PWM_MODE;
  endsequence
  chk_answer_once: assert property (cmd_valid_i |=> cmd_ack_o ^ cmd_nack_o)
    else $error("command not answered by exactly one of ack or nack");
  chk_clock_busy: assert property (s_clk_wr and |chan_enable_o
    |=> cmd_nack_o && busy_fault_o)
    else $error("shared clock write accepted while a channel runs");
  chk_phase_decode: assert property (s_clk_wr ##1 cmd_ack_o
    |-> {phase_ch0_deg_o, phase_ch1_deg_o, duty_cap_o}
        == tbl($past(cmd_data_i)))
    else $error("phase or duty cap does not match written field");
  chk_mode_busy: assert property ((s_mode_wr and cmd_page_i != 2'd2
    && |(chan_enable_o & ((cmd_page_i == 2'd3) ? 2'b11
                          : (2'b01 << cmd_page_i)))) |=> cmd_nack_o)
    else $error("mode write accepted while addressed channel runs");
  chk_fault_hold: assert property (busy_fault_o && !clear_faults_i
    |=> busy_fault_o)
    else $error("busy fault dropped without a clear");
  chk_clock_on: assert property (input_on_threshold_i [*4]
    |-> ##[0:2] shared_phase_clock_en_o)
    else $error("shared clock not enabled with input above on level");
  chk_enable_cause: assert property ($rose(chan_enable_o[0])
    |-> $past(chan_on_cmd_i[0]))
    else $error("channel enabled without an on command");
  chk_servo_gate: assert property (!load_line_zero_i[0]
    && !$past(load_line_zero_i[0]) |-> !servo_en_o[0])
    else $error("servo enabled with nonzero load line");
  chk_dcm_suppress: assert property (dcm_allowed_o[0]
    |-> overshoot_resp_en_o[0])
    else $error("discontinuous mode allowed while suppressed");
  chk_bootstrap_refresh_legal: assert property (bootstrap_refresh_width_ns_o[0] inside
    {8'h19, 8'h32, 8'h7D, 8'hFA})
    else $error("bootstrap refresh width not a legal value");
  chk_rd_stable: assert property ($changed(rd_data_o)
    |-> $past(cmd_valid_i && !cmd_write_i))
    else $error("read data changed without a read");
endmodule
bind pccr_top pccr_checker #(.MS_CYCLES_P(MS_CYCLES_P)) i_chk (
  .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
  .cmd_page_i(cmd_page_i), .cmd_data_i(cmd_data_i),
  .cmd_ack_o(cmd_ack_o), .cmd_nack_o(cmd_nack_o),
  .rd_data_o(rd_data_o), .busy_fault_o(busy_fault_o),
  .clear_faults_i(clear_faults_i),
  .input_on_threshold_i(input_on_threshold_i),
  .shared_phase_clock_en_o(shared_phase_clock_en_o),
  .chan_on_cmd_i(chan_on_cmd_i), .load_line_zero_i(load_line_zero_i),
  .chan_enable_o(chan_enable_o), .phase_ch0_deg_o(phase_ch0_deg_o),
  .phase_ch1_deg_o(phase_ch1_deg_o), .duty_cap_o(duty_cap_o),
  .servo_en_o(servo_en_o), .bootstrap_refresh_width_ns_o(bootstrap_refresh_width_ns_o),
  .dcm_allowed_o(dcm_allowed_o),
  .overshoot_resp_en_o(overshoot_resp_en_o)
);
`default_nettype wire

/* tb/pwm_channel_config_regs_tb_top.sv */
// Purpose: self-checking bench for the PWM configuration command bank
// Assumes: one ms shortened to 10 cycles; inputs change at falling edge
// Notes:   comparator and decay flags are driven directly
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_config_regs_tb_top;
  import pccr_pkg::*;
  localparam int MSC = 10;
  localparam int LIMIT = 20000;
  logic       clk_i, reset_i, clr, on_th, off_th, valid, wr, ack, nack;
  logic       fault, sclk, cap;
  logic [7:0] code, data, rd;
  logic [1:0] page, on_cmd, decayed, llz, en, oe, lr, servo, tdir, discontinuous_conduction, osr;
  logic [8:0] ph0, ph1;
  logic [1:0] run;
  logic [15:0] dly, ramp, rwait;
  logic [7:0] bw [2];
  int         failures = 0, total_checks = 0, cycles = 0, n;
  pccr_host_model i_host (.clk_i(clk_i), .ack_i(ack), .nack_i(nack),
    .rd_i(rd), .valid_o(valid), .write_o(wr), .code_o(code),
    .page_o(page), .data_o(data));
  pccr_top #(.MS_CYCLES_P(MSC)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .cmd_valid_i(valid), .cmd_write_i(wr), .cmd_code_i(code),
    .cmd_page_i(page), .cmd_data_i(data), .cmd_ack_o(ack),
    .cmd_nack_o(nack), .rd_data_o(rd), .busy_fault_o(fault),
    .clear_faults_i(clr), .input_on_threshold_i(on_th),
    .input_off_threshold_i(off_th), .shared_phase_clock_en_o(sclk),
    .chan_on_cmd_i(on_cmd), .output_decayed_i(decayed),
    .load_line_zero_i(llz), .turn_off_delay_ms_i(dly),
    .turn_off_ramp_time_ms_i(ramp), .restart_wait_time_ms_i(rwait),
    .chan_enable_o(en), .channel_run_input_o(run),
    .channel_run_input_oe_o(oe), .phase_ch0_deg_o(ph0),
    .phase_ch1_deg_o(ph1), .duty_cap_o(cap), .low_range_o(lr),
    .servo_en_o(servo), .temp_direct_o(tdir), .bootstrap_refresh_width_ns_o(bw),
    .dcm_allowed_o(discontinuous_conduction), .overshoot_resp_en_o(osr));
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [1:0] p,
                     input logic [7:0] d, input logic [1:0] e_an,
                     input logic [7:0] e_rd);
    logic [1:0] a;
    logic [7:0] r;
    i_host.xfer(w, c, p, d, a, r);
    chk({14'h0000, a}, {14'h0000, e_an});
    if (!w)
      chk({8'h00, r}, {8'h00, e_rd});
  endtask
  // Bounded wait for the masked enables to reach a value
  task automatic wait_for(input logic [1:0] m, input logic [1:0] v);
    n = 0;
    while ((en & m) !== v && n < 4000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(en & m, v);
  endtask
  task automatic t_defaults();
    cmd(0, CODE_CLOCK_CFG, 2'd0, 8'h00, 2'b10, RST_CLOCK_CFG);
    cmd(0, CODE_CHAN_CFG, 2'd1, 8'h00, 2'b10, RST_CHAN_CFG);
    cmd(0, CODE_PWM_MODE, 2'd0, 8'h00, 2'b10, RST_PWM_MODE);
    cmd(0, 8'h33, 2'd0, 8'h00, 2'b01, 8'h00);
    on_th = 1'b1;
    repeat (5) @(negedge clk_i);
    chk(sclk, 1'b1);
  endtask
  task automatic t_phase();
    logic [8:0] p0 [8] = '{9'h000, 9'h000, 9'h03C, 9'h078,
                           9'h000, 9'h02D, 9'h05A, 9'h087};
    logic [8:0] p1 [8] = '{9'h078, 9'h0B4, 9'h0F0, 9'h12C,
                           9'h0B4, 9'h0E1, 9'h10E, 9'h13B};
    for (int i = 0; i < 8; i++)
    begin
      cmd(1, CODE_CLOCK_CFG, 2'd0, 8'hC0 | i[7:0], 2'b10, 8'h00);
      chk(ph0, p0[i]);
      chk(ph1, p1[i]);
      chk(cap, i[2]);
      cmd(0, CODE_CLOCK_CFG, 2'd0, 8'h00, 2'b10, i[7:0]);
    end
    // Gating is off now, so a sag below off-level must not stop the clock
    {on_th, off_th} = 2'b01;
    repeat (6) @(negedge clk_i);
    chk(sclk, 1'b1);
    {on_th, off_th} = 2'b10;
  endtask
  task automatic t_mode();
    logic [7:0] m [4] = '{8'h00, 8'h69, 8'hB2, 8'hDB};
    logic [7:0] w [4] = '{8'h19, 8'h32, 8'h7D, 8'hFA};
    llz = 2'b11;
    foreach (m[i])
    begin
      cmd(1, CODE_PWM_MODE, 2'd3, m[i], 2'b10, 8'h00);
      chk({lr[0], servo[0], tdir[0]}, m[i][7:5]);
      chk({lr[1], servo[1], tdir[1]}, m[i][7:5]);
      chk({discontinuous_conduction, osr}, {{2{m[i][0] & ~m[i][1]}}, {2{~m[i][1]}}});
      chk(bw[0], w[m[i][4:3]]);
      chk(bw[1], w[m[i][4:3]]);
      cmd(0, CODE_PWM_MODE, 2'd1, 8'h00, 2'b10, m[i]);
    end
    llz = 2'b10;
    cmd(1, CODE_PWM_MODE, 2'd0, 8'h40, 2'b10, 8'h00);
    chk(servo[0], 1'b0);
  endtask
  task automatic t_busy();
    on_cmd = 2'b01;
    wait_for(2'b01, 2'b01);
    cmd(1, CODE_CLOCK_CFG, 2'd0, 8'h05, 2'b01, 8'h00);
    chk(fault, 1'b1);
    cmd(0, CODE_CLOCK_CFG, 2'd0, 8'h00, 2'b10, 8'h07);
    cmd(1, CODE_PWM_MODE, 2'd1, 8'h01, 2'b10, 8'h00);
    cmd(1, CODE_PWM_MODE, 2'd3, 8'h03, 2'b01, 8'h00);
    cmd(0, CODE_PWM_MODE, 2'd0, 8'h00, 2'b10, 8'h40);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    chk(fault, 1'b0);
    on_cmd = 2'b00;
    n = 0;
    repeat (20 * MSC) @(negedge clk_i) n += oe[0];
    chk(n[15:0], 16'h0000);
  endtask
  task automatic t_pulse();
    cmd(1, CODE_CHAN_CFG, 2'd0, 8'h05, 2'b10, 8'h00);
    on_cmd = 2'b01;
    wait_for(2'b01, 2'b01);
    on_cmd = 2'b00;
    // Count from the first cycle of the pulse; it starts one edge after off
    n = 0;
    repeat (2) @(negedge clk_i) n += oe[0];
    chk(en[0], 1'b1);
    chk(run[0], 1'b0);
    repeat (160 * MSC - 2) @(negedge clk_i) n += oe[0];
    // Off delay 3 ms plus ramp 2 ms plus 136 ms, tick phase takes off up to 1 ms
    chk(n >= 140 * MSC && n <= 142 * MSC, 1'b1);
  endtask
  task automatic t_short();
    cmd(1, CODE_CHAN_CFG, 2'd0, 8'h19, 2'b10, 8'h00);
    on_cmd = 2'b01;
    wait_for(2'b01, 2'b01);
    on_cmd = 2'b00;
    repeat (3) @(negedge clk_i);
    on_cmd = 2'b01;
    repeat (3) @(negedge clk_i);
    chk(en[0], 1'b0);
    wait_for(2'b01, 2'b01);
    chk(n >= 118 * MSC, 1'b1);
    on_cmd = 2'b00;
    wait_for(2'b01, 2'b00);
  endtask
  task automatic t_gate();
    cmd(1, CODE_CLOCK_CFG, 2'd0, 8'h17, 2'b10, 8'h00);
    cmd(1, CODE_CHAN_CFG, 2'd0, 8'h1D, 2'b10, 8'h00);
    cmd(1, CODE_CHAN_CFG, 2'd1, 8'h00, 2'b10, 8'h00);
    on_cmd = 2'b11;
    repeat (20) @(negedge clk_i);
    chk(en, 2'b01);
    decayed = 2'b11;
    wait_for(2'b10, 2'b10);
    on_th = 1'b0;
    off_th = 1'b1;
    repeat (6) @(negedge clk_i);
    chk({sclk, en}, 3'b010);
    off_th = 1'b0;
    repeat (6) @(negedge clk_i);
    chk(sclk, 1'b0);
    on_th = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(sclk, 1'b1);
    on_cmd = 2'b00;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    {reset_i, clr, on_th, off_th} = 4'h8;
    {on_cmd, decayed, llz} = 6'h00;
    dly = 16'h0003;
    ramp = 16'h0002;
    rwait = 16'h0000;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    t_defaults();
    t_phase();
    t_mode();
    t_busy();
    t_pulse();
    t_short();
    t_gate();
    conclude();
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      conclude();
    end
  end
endmodule
`default_nettype wire
